// ---- ofr_cfg.svh ----
// Purpose: Offsets, reset values, limits and timing counts of the ramp
// Assumes: Frequencies in 0.01 Hz steps, times in 0.01 s steps
// Notes:   Included by the divider, the ramp generator and its bench
`ifndef OFR_CFG_SVH
`define OFR_CFG_SVH

// Register byte offsets
`define OFR_A_ACC1   8'h00
`define OFR_A_DEC1   8'h04
`define OFR_A_REF    8'h08
`define OFR_A_ACC2   8'h0C
`define OFR_A_DEC2   8'h10
`define OFR_A_START  8'h14
`define OFR_A_HOLD   8'h18
`define OFR_A_BASE   8'h1C
`define OFR_A_SHAPE  8'h20
`define OFR_A_EXT    8'h24
`define OFR_A_FUNC   8'h28
`define OFR_A_GAINA  8'h2C
`define OFR_A_GAINB  8'h30
`define OFR_A_TARGET 8'h34
`define OFR_A_STATUS 8'h38

// Reset values
`define OFR_RST_TIME  20'h001F4
`define OFR_RST_REF   16'h1770
`define OFR_RST_DEC2  20'h0270F
`define OFR_RST_START 16'h0032
`define OFR_RST_HOLD  20'h0270F
`define OFR_RST_BASE  16'h1770
`define OFR_RST_GAIN  16'h1770

// Limits and codes
`define OFR_NO_VALUE   20'h0270F
`define OFR_TIME_MAX   20'h57E40
`define OFR_TIME_FLOOR 20'h00003
`define OFR_TIME_MIN   20'h00004
`define OFR_HOLD_MAX   20'h003E8
`define OFR_REF_MIN    16'h0064
`define OFR_REF_MAX    16'h9C40
`define OFR_REF_HALF   16'h2EE0
`define OFR_START_MAX  16'h1770
`define OFR_ZERO_START 16'h0001
`define OFR_RT_CODE    8'h03
`define OFR_SHAPE_MAX  2'h2

// Timing
`define OFR_CLK_NS      32'h00000004
`define OFR_TICK_NS     32'h000F4240
`define OFR_TICK_CYCLES (`OFR_TICK_NS / `OFR_CLK_NS)
`define OFR_MS_PER_UNIT 48'h00000000000A
`define OFR_DIV_W       48

`endif

// ---- ofr_pkg.sv ----
// Purpose: Types shared by the ramp generator files
// Assumes: Nothing beyond ofr_cfg.svh
// Notes:   Status struct is also the status register layout, MSB first
package ofr_pkg;

  typedef enum logic [1:0] {
    OFR_IDLE  = 2'b00,
    OFR_HOLD  = 2'b01,
    OFR_RAMP  = 2'b10,
    OFR_DECEL = 2'b11
  } ofr_state_t;

  typedef enum logic [1:0] {
    OFR_LINEAR = 2'b00,
    OFR_S_A    = 2'b01,
    OFR_S_B    = 2'b10
  } ofr_shape_t;

  typedef struct packed {
    logic       running;
    logic       sec_active;
    ofr_state_t state;
    logic [15:0] out_freq;
  } ofr_status_t;

endpackage

// ---- ofr_div.sv ----
// Purpose: Serial restoring divider for the per-tick frequency step
// Assumes: den is non-zero; start ignored while busy
// Notes:   Result is valid with done, W+1 edges after start is taken
`timescale 1ns/1ps
`include "ofr_cfg.svh"
module ofr_div #(
  parameter int W = `OFR_DIV_W
) (
  // Clock and reset
  input  wire logic         sys_clk,
  input  wire logic         rst,
  // Request
  input  wire logic         start,
  input  wire logic [W-1:0] num,
  input  wire logic [W-1:0] den,
  // Result
  output logic              busy,
  output logic              done,
  output logic [W-1:0]      quo,
  output logic [W-1:0]      rem
);
  localparam int LAT = W + 1;
  logic [W:0]   part;
  logic [W:0]   trial;
  logic [W-1:0] dq;
  logic [7:0]   cnt;

  always_comb
  begin
    trial = {part[W-1:0], quo[W-1]};
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      part <= '0;
      quo  <= '0;
      dq   <= '0;
      cnt  <= 8'h00;
      busy <= 1'b0;
      done <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      if (start && !busy)
      begin
        part <= '0;
        quo  <= num;
        dq   <= den;
        cnt  <= 8'(W);
        busy <= 1'b1;
      end
      else if (busy)
      begin
        if (trial >= {1'b0, dq})
        begin
          part <= trial - {1'b0, dq};
          quo  <= {quo[W-2:0], 1'b1};
        end
        else
        begin
          part <= trial;
          quo  <= {quo[W-2:0], 1'b0};
        end
        cnt <= cnt - 8'h01;
        if (cnt == 8'h01)
        begin
          busy <= 1'b0;
          done <= 1'b1;
        end
      end
    end
  end

  assign rem = part[W-1:0];

  a_div_latency: assert property (@(posedge sys_clk) disable iff (rst) // R20
    start && !busy |-> ##LAT done)
    else $error("divider result late or early");

endmodule // ofr_div

// ---- ofr_ramp.sv ----
// Purpose: Output frequency ramp generator with AXI4-Lite settings
// Assumes: start_cmd and second_function_select are async contact pins
// Notes:   S-pattern B runs as linear; one step per 1 ms control tick
// What this block does
// R1 - Accel time spans 0Hz to reference frequency
// R2 - Decel time spans reference frequency to 0Hz
// R3 - Reference frequency 1 to 400Hz, default 60Hz
// R4 - Second select swaps in second ramp times
// R5 - Second accel time 0 to 3600s
// R6 - Second decel 9999 reuses second accel time
// R7 - Second select needs terminal function code 3
// R8 - Times of 0.03s or less run 0.04s
// R9 - S-pattern A times target base frequency
// R10 - S-pattern A above base follows quadratic time
// R11 - Start begins at starting frequency, 0-60Hz
// R12 - Hold starting frequency for hold time
// R13 - Hold time 0 to 10s, 9999 disables
// R14 - Reference write leaves setting gains alone
// R15 - Second select enables all second functions
// R16 - Listed settings writable only when display select 0
// R17 - Start dropped during hold decelerates at once
// R18 - Zero starting frequency holds at 0.01Hz
// R19 - Shape codes: linear 0, A 1, B 2
// R20 - Each tick steps by reference over time
`timescale 1ns/1ps
`include "ofr_cfg.svh"
module ofr_ramp #(
  parameter int TICK_CYCLES = `OFR_TICK_CYCLES
) (
  // Clock and reset
  input  wire logic         sys_clk,
  input  wire logic         rst,
  // AXI4-Lite write
  input  wire logic [7:0]   s_axi_awaddr,
  input  wire logic         s_axi_awvalid,
  output logic              s_axi_awready,
  input  wire logic [31:0]  s_axi_wdata,
  input  wire logic [3:0]   s_axi_wstrb,
  input  wire logic         s_axi_wvalid,
  output logic              s_axi_wready,
  output logic [1:0]        s_axi_bresp,
  output logic              s_axi_bvalid,
  input  wire logic         s_axi_bready,
  // AXI4-Lite read
  input  wire logic [7:0]   s_axi_araddr,
  input  wire logic         s_axi_arvalid,
  output logic              s_axi_arready,
  output logic [31:0]       s_axi_rdata,
  output logic [1:0]        s_axi_rresp,
  output logic              s_axi_rvalid,
  input  wire logic         s_axi_rready,
  // Contact inputs
  input  wire logic         start_cmd,
  input  wire logic         second_function_select,
  // Drive outputs
  output ofr_pkg::ofr_status_t status
);
  import ofr_pkg::*;

  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);

  logic [19:0] acc1, dec1, acc2, dec2, hold;
  logic [15:0] ref_f, start_f, base_f, gain_a, gain_b, target;
  logic [7:0]  ext_disp, term_func;
  ofr_shape_t  shape;
  logic        start_m, start_s, rt_m, rt_s, sec_q;
  ofr_state_t  state;
  logic [15:0] out_freq;

  // Two-flop synchronisers for the contact pins
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      start_m <= 1'b0;
      start_s <= 1'b0;
      rt_m    <= 1'b0;
      rt_s    <= 1'b0;
    end
    else
    begin
      start_m <= start_cmd;
      start_s <= start_m;
      rt_m    <= second_function_select;
      rt_s    <= rt_m;
    end
  end

  // AXI4-Lite slave: address and data caught in either order
  logic        aw_held, w_held, wr_fire, wr_ok;
  logic [7:0]  aw_q;
  logic [31:0] wd_q, wv, cur;
  logic [3:0]  ws_q;
  logic        cur_hit;

  function automatic logic [31:0] reg_read(input logic [7:0] a);
    case (a)
      `OFR_A_ACC1:   reg_read = {12'h000, acc1};
      `OFR_A_DEC1:   reg_read = {12'h000, dec1};
      `OFR_A_REF:    reg_read = {16'h0000, ref_f};
      `OFR_A_ACC2:   reg_read = {12'h000, acc2};
      `OFR_A_DEC2:   reg_read = {12'h000, dec2};
      `OFR_A_START:  reg_read = {16'h0000, start_f};
      `OFR_A_HOLD:   reg_read = {12'h000, hold};
      `OFR_A_BASE:   reg_read = {16'h0000, base_f};
      `OFR_A_SHAPE:  reg_read = {30'h00000000, shape};
      `OFR_A_EXT:    reg_read = {24'h000000, ext_disp};
      `OFR_A_FUNC:   reg_read = {24'h000000, term_func};
      `OFR_A_GAINA:  reg_read = {16'h0000, gain_a};
      `OFR_A_GAINB:  reg_read = {16'h0000, gain_b};
      `OFR_A_TARGET: reg_read = {16'h0000, target};
      `OFR_A_STATUS: reg_read = {12'h000, status};
      default:       reg_read = 32'h00000000;
    endcase
  endfunction

  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign wr_fire       = aw_held && w_held && !s_axi_bvalid;

  always_comb
  begin
    cur = reg_read(aw_q);
    for (int i = 0; i < 4; i++)
      wv[8*i +: 8] = ws_q[i] ? wd_q[8*i +: 8] : cur[8*i +: 8];
  end

  // Out-of-range and locked writes are refused with SLVERR
  always_comb
  begin
    case (aw_q)
      `OFR_A_ACC1, `OFR_A_DEC1:
        wr_ok = wv[31:20] == 12'h000 && wv[19:0] <= `OFR_TIME_MAX;
      `OFR_A_REF:
        wr_ok = ext_disp == 8'h00 && wv[31:16] == 16'h0000 && // R16
                wv[15:0] >= `OFR_REF_MIN && wv[15:0] <= `OFR_REF_MAX; // R3
      `OFR_A_ACC2:
        wr_ok = ext_disp == 8'h00 && wv[31:20] == 12'h000 &&
                wv[19:0] <= `OFR_TIME_MAX; // R5
      `OFR_A_DEC2:
        wr_ok = ext_disp == 8'h00 && wv[31:20] == 12'h000 &&
                (wv[19:0] <= `OFR_TIME_MAX ||
                 wv[19:0] == `OFR_NO_VALUE); // R6
      `OFR_A_START:
        wr_ok = ext_disp == 8'h00 && wv[31:16] == 16'h0000 &&
                wv[15:0] <= `OFR_START_MAX; // R11
      `OFR_A_HOLD:
        wr_ok = ext_disp == 8'h00 && wv[31:20] == 12'h000 &&
                (wv[19:0] <= `OFR_HOLD_MAX ||
                 wv[19:0] == `OFR_NO_VALUE); // R13
      `OFR_A_SHAPE:
        wr_ok = ext_disp == 8'h00 && wv[31:2] == 30'h00000000 &&
                wv[1:0] <= `OFR_SHAPE_MAX; // R19
      `OFR_A_BASE:
        wr_ok = wv[31:16] == 16'h0000 && wv[15:0] != 16'h0000;
      `OFR_A_EXT, `OFR_A_FUNC:
        wr_ok = wv[31:8] == 24'h000000;
      `OFR_A_GAINA, `OFR_A_GAINB, `OFR_A_TARGET:
        wr_ok = wv[31:16] == 16'h0000;
      default:
        wr_ok = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      aw_held      <= 1'b0;
      w_held       <= 1'b0;
      aw_q         <= 8'h00;
      wd_q         <= 32'h00000000;
      ws_q         <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'b00;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held <= 1'b1;
        aw_q    <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held <= 1'b1;
        wd_q   <= s_axi_wdata;
        ws_q   <= s_axi_wstrb;
      end
      if (wr_fire)
      begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? 2'b00 : 2'b10;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= 2'b00;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= reg_read(s_axi_araddr);
      s_axi_rresp  <= (s_axi_araddr[1:0] == 2'b00 &&
                       s_axi_araddr <= `OFR_A_STATUS) ? 2'b00 : 2'b10;
    end
    else if (s_axi_rvalid && s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // Settings; the reference write touches no gain register
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      acc1 <= `OFR_RST_TIME;   dec1 <= `OFR_RST_TIME;
      acc2 <= `OFR_RST_TIME;   dec2 <= `OFR_RST_DEC2;
      ref_f <= `OFR_RST_REF;   start_f <= `OFR_RST_START;
      hold <= `OFR_RST_HOLD;   base_f <= `OFR_RST_BASE;
      shape <= OFR_LINEAR;     ext_disp <= 8'h00;
      term_func <= 8'h00;      target <= 16'h0000;
      gain_a <= `OFR_RST_GAIN; gain_b <= `OFR_RST_GAIN;
    end
    else if (wr_fire && wr_ok)
    begin
      case (aw_q)
        `OFR_A_ACC1:   acc1 <= wv[19:0];
        `OFR_A_DEC1:   dec1 <= wv[19:0];
        `OFR_A_REF:    ref_f <= wv[15:0]; // R14
        `OFR_A_ACC2:   acc2 <= wv[19:0];
        `OFR_A_DEC2:   dec2 <= wv[19:0];
        `OFR_A_START:  start_f <= wv[15:0];
        `OFR_A_HOLD:   hold <= wv[19:0];
        `OFR_A_BASE:   base_f <= wv[15:0];
        `OFR_A_SHAPE:  shape <= ofr_shape_t'(wv[1:0]);
        `OFR_A_EXT:    ext_disp <= wv[7:0];
        `OFR_A_FUNC:   term_func <= wv[7:0];
        `OFR_A_GAINA:  gain_a <= wv[15:0];
        `OFR_A_GAINB:  gain_b <= wv[15:0];
        `OFR_A_TARGET: target <= wv[15:0];
        default:       ;
      endcase
    end
  end

  // Second function only counts once a terminal carries its code
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      sec_q <= 1'b0;
    else
      sec_q <= rt_s && term_func == `OFR_RT_CODE; // R7 R15
  end

  logic [19:0] t_acc_raw, t_dec_raw, t_acc, t_dec;
  logic [15:0] start_eff, goal, diff, fb_eff;
  logic        up, sa_hi, div_go, div_done, tick;
  logic [47:0] tms, inc, den, num, quo, drem, rem_q;

  always_comb
  begin
    t_acc_raw = sec_q ? acc2 : acc1; // R1 R4
    t_dec_raw = !sec_q ? dec1 : // R2
                (dec2 == `OFR_NO_VALUE ? acc2 : dec2); // R6
    t_acc = t_acc_raw <= `OFR_TIME_FLOOR ? `OFR_TIME_MIN : t_acc_raw; // R8
    t_dec = t_dec_raw <= `OFR_TIME_FLOOR ? `OFR_TIME_MIN : t_dec_raw; // R8
    start_eff = start_f == 16'h0000 ? `OFR_ZERO_START : start_f; // R18
    goal = !start_s ? 16'h0000 : (target > start_eff ? target : start_eff);
    up   = goal > out_freq;
    diff = up ? goal - out_freq : out_freq - goal;
    tms  = {28'h0000000, up ? t_acc : t_dec} * `OFR_MS_PER_UNIT;
    fb_eff = shape == OFR_S_A ? base_f : ref_f; // R9
    sa_hi  = shape == OFR_S_A && out_freq >= base_f;
    // Above base the slope falls as 1/f so total time is quadratic
    inc = sa_hi ? 48'h000000000009 * {32'h0, base_f} * {32'h0, base_f}
                : {32'h0, fb_eff}; // R10 R20
    den = sa_hi ? 48'h000000000008 * tms * {32'h0, out_freq} : tms; // R10
    num = rem_q + inc;
  end

  logic [17:0] tick_cnt;
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      tick_cnt <= 18'h00000;
      tick     <= 1'b0;
    end
    else
    begin
      tick     <= tick_cnt == 18'(TICK_CYCLES - 1);
      tick_cnt <= tick_cnt == 18'(TICK_CYCLES - 1) ? 18'h00000
                                                   : tick_cnt + 18'h00001;
    end
  end

  logic div_busy;
  assign div_go = tick && (state == OFR_RAMP || state == OFR_DECEL) &&
                  out_freq != goal;

  ofr_div #(.W(`OFR_DIV_W)) u_div (
    .sys_clk (sys_clk),
    .rst     (rst),
    .start   (div_go),
    .num     (num),
    .den     (den),
    .busy    (div_busy),
    .done    (div_done),
    .quo     (quo),
    .rem     (drem)
  );

  logic [13:0] hold_cnt;
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      state    <= OFR_IDLE;
      out_freq <= 16'h0000;
      hold_cnt <= 14'h0000;
      rem_q    <= 48'h000000000000;
    end
    else
    begin
      unique case (state)
        OFR_IDLE:
          if (start_s)
          begin
            out_freq <= start_eff; // R11
            hold_cnt <= 14'(hold * 20'h0000A);
            rem_q    <= 48'h000000000000;
            state <= (hold == `OFR_NO_VALUE || hold == 20'h00000)
                     ? OFR_RAMP : OFR_HOLD; // R13
          end
        OFR_HOLD:
          if (!start_s)
            state <= OFR_DECEL; // R17
          else if (tick)
          begin
            hold_cnt <= hold_cnt - 14'h0001; // R12
            if (hold_cnt <= 14'h0001)
              state <= OFR_RAMP;
          end
        OFR_RAMP, OFR_DECEL:
        begin
          state <= start_s ? OFR_RAMP : OFR_DECEL;
          if (div_done)
          begin
            rem_q <= drem;
            if (quo >= {32'h0, diff})
              out_freq <= goal;
            else if (up)
              out_freq <= out_freq + quo[15:0]; // R20
            else
              out_freq <= out_freq - quo[15:0];
          end
          else if (!start_s && out_freq == 16'h0000 && !div_busy)
            state <= OFR_IDLE;
        end
      endcase
    end
  end

  assign status = '{running: state != OFR_IDLE, sec_active: sec_q,
                    state: state, out_freq: out_freq};

  a_idle_zero: assert property (state == OFR_IDLE |-> out_freq == 0) // R2
    else $error("idle with nonzero output");
  a_start_freq: assert property (state == OFR_IDLE && start_s |=> // R11
    state != OFR_IDLE && out_freq == $past(start_eff))
    else $error("start did not load starting frequency");
  a_zero_start: assert property (start_s && start_f == 0 && // R18
    state == OFR_IDLE |=> out_freq == 16'h0001)
    else $error("zero start not held at 0.01Hz");
  // A settings write during hold must not disturb the held output
  a_hold_level: assert property (state == OFR_HOLD && // R12
    $past(state) == OFR_HOLD |-> $stable(out_freq))
    else $error("output moved during hold");
  a_hold_abort: assert property (state == OFR_HOLD && !start_s // R17
    |=> state == OFR_DECEL)
    else $error("hold not aborted on stop");
  a_hold_skip: assert property (state == OFR_IDLE && start_s && // R13
    hold == 20'h0270F |=> state == OFR_RAMP)
    else $error("disabled hold still held");
  a_min_time: assert property (t_acc >= 20'h00004 && // R8
    t_dec >= 20'h00004)
    else $error("ramp time below 0.04s");
  a_rt_gate: assert property (sec_q |-> $past(rt_s) && // R7
    $past(term_func) == 8'h03)
    else $error("second function without code 3");
  a_dec_alias: assert property (sec_q && dec2 == 20'h0270F |-> // R6
    t_dec == t_acc)
    else $error("second decel not aliased");
  a_ref_range: assert property (ref_f >= 16'h0064 && // R3
    ref_f <= 16'h9C40)
    else $error("reference frequency out of range");
  a_lock_ref: assert property (wr_fire && aw_q == 8'h08 && // R16
    ext_disp != 8'h00 |=> $stable(ref_f) && s_axi_bresp == 2'b10)
    else $error("locked reference written");
  a_gain_keep: assert property (wr_fire && aw_q == 8'h08 |=> // R14
    $stable(gain_a) && $stable(gain_b))
    else $error("gain changed by reference write");
  a_step_cause: assert property ($changed(out_freq) && // R20
    $past(state) inside {OFR_RAMP, OFR_DECEL} |-> $past(div_done))
    else $error("output stepped without a tick result");

endmodule // ofr_ramp

// ---- ofr_contacts.sv ----
// Purpose: Contact model for the start and second select pins
// Assumes: Contacts settle cleanly, no bounce
// Notes:   lag picks 1 to 4 cycles of pin delay, prompt or slow
`timescale 1ns/1ps
module ofr_contacts (
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst,
  // Requests from the bench
  input  wire logic       want_start,
  input  wire logic       want_sec,
  input  wire logic [1:0] lag,
  // Contact pins
  output logic            start_cmd,
  output logic            second_function_select
);
  logic [3:0] s_pipe;
  logic [3:0] r_pipe;

  always_ff @(posedge sys_clk or posedge rst)
    if (rst)
    begin
      s_pipe <= 4'h0;
      r_pipe <= 4'h0;
    end
    else
    begin
      s_pipe <= {s_pipe[2:0], want_start};
      r_pipe <= {r_pipe[2:0], want_sec};
    end

  // Lag only changes while both pins rest, so no glitch reaches the pins
  assign start_cmd              = s_pipe[lag];
  assign second_function_select = r_pipe[lag];
endmodule // ofr_contacts

// ---- test_ofr_ramp.sv ----
// Purpose: Self-checking bench of the ramp generator
// Assumes: Short control tick of 200 cycles
// Notes:   Rates are measured over ten ticks, one count of slack
`timescale 1ns/1ps
`include "ofr_cfg.svh"
module test_ofr_ramp;
  import ofr_pkg::*;
  localparam int TK = 200;
  logic        sys_clk, rst, awvalid, awready, wvalid, wready;
  logic        bvalid, bready, arvalid, arready, rvalid, rready;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, lag;
  logic        want_start, want_sec, start_pin, sec_pin;
  ofr_status_t status;
  logic [7:0]  ra [11];
  logic [31:0] rv [11];
  int          mismatches, n_checks, seed, rf, tm;

  ofr_ramp #(.TICK_CYCLES(TK)) DUT (
    .sys_clk(sys_clk), .rst(rst), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .start_cmd(start_pin),
    .second_function_select(sec_pin), .status(status));

  ofr_contacts contacts (
    .sys_clk(sys_clk), .rst(rst), .want_start(want_start),
    .want_sec(want_sec), .lag(lag), .start_cmd(start_pin),
    .second_function_select(sec_pin));

  initial
  begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  task automatic chk(input logic [33:0] g, input logic [33:0] e);
    n_checks++;
    if (g !== e)
    begin
      mismatches++;
      $display("[FAIL] %0t got %0h want %0h", $time, g, e);
    end
  endtask

  task automatic chk_rate(input logic [15:0] f0, input logic [15:0] f1,
                          input int e);
    int dl;
    dl = int'(f1) - int'(f0);
    n_checks++;
    if ((^{f0, f1}) === 1'bx || dl < e - 1 || dl > e + 1)
    begin
      mismatches++;
      $display("[FAIL] %0t rate %0d want %0d", $time, dl, e);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v,
                    input logic [1:0] e);
    int n;
    n = 0;
    @(posedge sys_clk);
    awaddr  <= a;
    wdata   <= v;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do
    begin
      @(posedge sys_clk);
      n++;
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
    end
    while (bvalid !== 1'b1 && n < 99);
    bready <= 1'b0;
    chk({31'h0, bvalid, bresp}, {31'h0, 1'b1, e});
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [1:0] er);
    int n;
    n = 0;
    @(posedge sys_clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do
    begin
      @(posedge sys_clk);
      n++;
      if (arvalid && arready)
        arvalid <= 1'b0;
    end
    while (rvalid !== 1'b1 && n < 99);
    rready <= 1'b0;
    // A missing answer flips every bit so it can never pass
    chk({rresp, rdata} ^ {34{rvalid !== 1'b1}}, {er, e});
  endtask

  task automatic wait_st(input ofr_state_t s, input int lim);
    int n;
    n = 0;
    while (status.state !== s && n < lim)
    begin
      @(posedge sys_clk);
      n++;
    end
    chk({31'h0, status.running, status.state}, {31'h0, s != OFR_IDLE, s});
  endtask

  // Ten-tick change: reference over the time actually run, floor 0.04s
  function automatic int exp_rate(input int f, input int t);
    exp_rate = f / (t <= 3 ? 4 : t);
  endfunction

  // Ten ticks in any window of 10*TK cycles, whatever the phase
  task automatic meas(input int e);
    logic [15:0] f0;
    f0 = status.out_freq;
    repeat (10 * TK) @(posedge sys_clk);
    chk_rate(f0, status.out_freq, e);
  endtask

  task automatic go(input logic on);
    if (on)
      lag <= 2'($random(seed));
    want_start <= on;
  endtask

  task automatic end_of_test;
    if (mismatches == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial
  begin
    #360000;
    mismatches++;
    end_of_test();
  end

  initial
  begin
    seed = 32'h590D;
    {rst, awvalid, wvalid, bready, arvalid, rready} = 6'h20;
    {awaddr, araddr, wdata, wstrb, lag} = {48'h0, 4'hF, 2'h0};
    {want_start, want_sec} = 2'h0;
    ra = '{`OFR_A_ACC1, `OFR_A_DEC1, `OFR_A_REF, `OFR_A_ACC2, `OFR_A_DEC2,
           `OFR_A_START, `OFR_A_HOLD, `OFR_A_BASE, `OFR_A_SHAPE,
           `OFR_A_GAINA, `OFR_A_GAINB};
    rv = '{32'h1F4, 32'h1F4, 32'h1770, 32'h1F4, 32'h270F, 32'h32,
           32'h270F, 32'h1770, 32'h0, 32'h1770, 32'h1770};
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    foreach (ra[k])
      rd(ra[k], rv[k], 2'h0);
    rd(8'h3C, 32'h0, 2'h2);
    wr(`OFR_A_STATUS, 32'h0, 2'h2);
    wr(`OFR_A_REF, 32'h63, 2'h2);
    wr(`OFR_A_REF, 32'h9C41, 2'h2);
    wr(`OFR_A_REF, 32'h9C40, 2'h0);
    rd(`OFR_A_GAINA, 32'h1770, 2'h0);
    rd(`OFR_A_GAINB, 32'h1770, 2'h0);
    wr(`OFR_A_REF, 32'h1770, 2'h0);
    wr(`OFR_A_HOLD, 32'h3E9, 2'h2);
    wr(`OFR_A_HOLD, 32'h3E8, 2'h0);
    wr(`OFR_A_START, 32'h1771, 2'h2);
    wr(`OFR_A_ACC2, 32'h57E41, 2'h2);
    wr(`OFR_A_DEC2, 32'h57E41, 2'h2);
    for (int s = 3; s >= 0; s--)
      wr(`OFR_A_SHAPE, 32'(s), {s == 3, 1'b0});
    wr(`OFR_A_EXT, 32'h1, 2'h0);
    foreach (ra[k])
      if (k >= 2 && k <= 6)
        wr(ra[k], 32'h64, 2'h2);
    wr(`OFR_A_SHAPE, 32'h1, 2'h2);
    wr(`OFR_A_ACC1, 32'h64, 2'h0);
    wr(`OFR_A_DEC1, 32'h64, 2'h0);
    rd(`OFR_A_REF, 32'h1770, 2'h0);
    wr(`OFR_A_EXT, 32'h0, 2'h0);
    wr(`OFR_A_HOLD, 32'h2, 2'h0);
    wr(`OFR_A_TARGET, 32'h9C40, 2'h0);
    go(1'b1);
    wait_st(OFR_HOLD, 20);
    chk({18'h0, status.out_freq}, 34'h32);
    repeat (5 * TK) @(posedge sys_clk);
    chk({18'h0, status.out_freq}, 34'h32);
    go(1'b0);
    wait_st(OFR_DECEL, 20);
    wait_st(OFR_IDLE, 9000);
    wr(`OFR_A_START, 32'h0, 2'h0);
    go(1'b1);
    wait_st(OFR_HOLD, 20);
    chk({18'h0, status.out_freq}, 34'h1);
    repeat (15 * TK) @(posedge sys_clk);
    chk({32'h0, status.state}, {32'h0, OFR_HOLD});
    wait_st(OFR_RAMP, 10 * TK);
    go(1'b0);
    wait_st(OFR_IDLE, 9000);
    wr(`OFR_A_START, 32'h32, 2'h0);
    wr(`OFR_A_HOLD, 32'h270F, 2'h0);
    wr(`OFR_A_SHAPE, 32'h1, 2'h0);
    wr(`OFR_A_BASE, 32'hBB8, 2'h0);
    go(1'b1);
    wait_st(OFR_RAMP, 20);
    meas(30);
    go(1'b0);
    wait_st(OFR_IDLE, 20000);
    wr(`OFR_A_SHAPE, 32'h0, 2'h0);
    go(1'b1);
    wait_st(OFR_RAMP, 20);
    meas(60);
    want_sec <= 1'b1;
    repeat (10) @(posedge sys_clk);
    chk({33'h0, status.sec_active}, 34'h0);
    meas(60);
    wr(`OFR_A_FUNC, 32'h3, 2'h0);
    repeat (10) @(posedge sys_clk);
    chk({33'h0, status.sec_active}, 34'h1);
    wr(`OFR_A_ACC2, 32'h14, 2'h0);
    repeat (TK) @(posedge sys_clk);
    meas(300);
    go(1'b0);
    wait_st(OFR_DECEL, 20);
    meas(-300);
    want_sec <= 1'b0;
    repeat (TK) @(posedge sys_clk);
    meas(-60);
    wait_st(OFR_IDLE, 20000);
    go(1'b1);
    wait_st(OFR_RAMP, 20);
    // Random reference and time pairs keep the sum below the target
    repeat (6)
    begin
      rf = 100 + int'($unsigned($random(seed)) % 11900);
      tm = 100 + int'($unsigned($random(seed)) % 301);
      wr(`OFR_A_REF, 32'(rf), 2'h0);
      wr(`OFR_A_ACC1, 32'(tm), 2'h0);
      repeat (TK) @(posedge sys_clk);
      meas(exp_rate(rf, tm));
    end
    wr(`OFR_A_REF, 32'h1770, 2'h0);
    for (int t = 0; t < 5; t++)
    begin
      wr(`OFR_A_ACC1, 32'(t), 2'h0);
      repeat (TK) @(posedge sys_clk);
      meas(exp_rate(6000, t));
    end
    end_of_test();
  end
endmodule // test_ofr_ramp
